// ### rtl/window_defines.svh
// Timing and sizing constants of the window controller
`ifndef WINDOW_DEFINES_SVH
`define WINDOW_DEFINES_SVH
`define WIN_CLK_HZ        200000000
`define WIN_EXPRESS_MS    300
`define WIN_EXPRESS_CYC   ((`WIN_CLK_HZ / 1000) * `WIN_EXPRESS_MS)
`define WIN_CUTOFF_US     10000
`define WIN_CUTOFF_CYC    ((`WIN_CLK_HZ / 1000000) * `WIN_CUTOFF_US)
`define WIN_COUNT         4
`define WIN_ACC_CYC       1000
`define WIN_CNT_W         27
`endif

// ### rtl/window_pkg.sv
// Types shared by the window controller
package window_pkg;
	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0001,
		ST_MANUAL  = 4'b0010,
		ST_EXPRESS = 4'b0100,
		ST_BLOCKED = 4'b1000
	} win_state_e;
	typedef logic [1:0] drive_t;
endpackage : window_pkg

// ### rtl/window_channel.sv
// One window: mode machine, express timer and lock-current cut-off
`timescale 1ns/1ps
`include "window_defines.svh"
module window_channel #(
	parameter int EXPRESS_CYC = `WIN_EXPRESS_CYC,
	parameter int CUTOFF_CYC  = `WIN_CUTOFF_CYC
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic req_up,
	input  wire logic req_down,
	input  wire logic req_auto,
	input  wire logic enable,
	input  wire logic crank,
	input  wire logic over_run,
	input  wire logic over_lock,
	output logic      motor_up,
	output logic      motor_down
);
	import window_pkg::*;
	win_state_e             state_reg, state_next;
	logic                   dir_up_reg;
	logic [`WIN_CNT_W-1:0]  hold_reg;
	logic [`WIN_CNT_W-1:0]  lock_reg;
	logic                   up_reg, down_reg;
	wire any_req     = req_up | req_down;
	wire express_hit = req_down && !req_up &&
		(req_auto || hold_reg >= (`WIN_CNT_W)'(EXPRESS_CYC)); // R9 R14
	wire running     = (state_reg == ST_MANUAL || state_reg == ST_EXPRESS);
	wire lock_trip   = running && over_lock &&
		lock_reg >= (`WIN_CNT_W)'(CUTOFF_CYC - 1); // R2 R4 R18
	wire move_ok     = enable && !crank; // R6 R17
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (move_ok && express_hit)
					state_next = ST_EXPRESS;
				else if (move_ok && any_req)
					state_next = ST_MANUAL; // R1
			end
			ST_MANUAL: begin
				if (lock_trip)
					state_next = ST_BLOCKED; // R2
				else if (express_hit)
					state_next = ST_EXPRESS; // R14
				else if (!any_req)
					state_next = ST_IDLE; // R16
			end
			ST_EXPRESS: begin
				if (lock_trip)
					state_next = ST_BLOCKED; // R2
				else if (any_req && hold_reg == '0 && !crank)
					state_next = ST_BLOCKED; // R15
				else if (!enable)
					state_next = ST_IDLE;
			end
			ST_BLOCKED: begin
				if (!any_req)
					state_next = ST_IDLE; // R15
			end
			default: state_next = ST_IDLE;
		endcase
	end
	// Press age; zero while in express marks a fresh press
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !any_req)
			hold_reg <= '0;
		else if (hold_reg != '1)
			hold_reg <= hold_reg + 1'b1;
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !running || !over_lock || crank)
			lock_reg <= '0;
		else if (lock_reg != '1)
			lock_reg <= lock_reg + 1'b1; // R4
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg  <= ST_IDLE;
			dir_up_reg <= 1'b0;
			up_reg     <= 1'b0;
			down_reg   <= 1'b0;
		end else begin
			state_reg  <= state_next;
			if (state_reg == ST_IDLE)
				dir_up_reg <= req_up;
			up_reg   <= state_next == ST_MANUAL && !crank && enable &&
				(state_reg == ST_IDLE ? req_up : dir_up_reg) &&
				req_up; // R1 R16 R17
			down_reg <= !crank && enable && (state_next == ST_EXPRESS ||
				state_next == ST_MANUAL && req_down && !req_up &&
				!(state_reg == ST_IDLE ? req_up : dir_up_reg)); // R1 R17
		end
	end
	assign motor_up   = up_reg;
	assign motor_down = down_reg;
	chk_lock_cut : assert property (@(posedge clk_sys) disable iff (sys_rst)
		running && over_lock [*2] ##0 lock_trip |=> !motor_up[*1]
		##0 !motor_down) else $error("drive kept after lock cut"); // R4
	chk_crank_stop : assert property (@(posedge clk_sys) disable iff (sys_rst)
		crank |=> !motor_up && !motor_down)
		else $error("motor ran during crank"); // R17
	chk_enable_gate : assert property (@(posedge clk_sys) disable iff (sys_rst)
		!enable |=> !motor_up && !motor_down)
		else $error("motor ran without enable"); // R6
	chk_no_both_dir : assert property (@(posedge clk_sys) disable iff (sys_rst)
		!(motor_up && motor_down)) else $error("both directions driven"); // R1
	chk_manual_release : assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		state_reg == ST_MANUAL && !any_req && !lock_trip |=> !motor_up
		&& !motor_down) else $error("manual kept after release"); // R16
	chk_express_hold : assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		state_reg == ST_EXPRESS && enable && !crank && !any_req && !over_lock
		##1 enable && !crank |-> motor_down)
		else $error("express stopped early"); // R14
	chk_block_stays : assert property (@(posedge clk_sys) disable iff (sys_rst)
		state_reg == ST_BLOCKED && any_req |=> !motor_up && !motor_down)
		else $error("blocked window moved"); // R15
	chk_auto_decode : assert property (@(posedge clk_sys) disable iff (sys_rst)
		state_reg == ST_IDLE && enable && !crank && req_down && req_auto
		&& !req_up |=> state_reg == ST_EXPRESS)
		else $error("auto down not decoded"); // R9
endmodule : window_channel

// ### rtl/window_controller.sv
// Four-window power window controller top level
// How it works
// R1 - Drive each motor per switch mode
// R2 - Remove drive at end position
// R3 - Running and locking thresholds, locking higher
// R4 - Cut drive within delay after lock
// R5 - All windows independent and concurrent
// R6 - Move only while ignition enables
// R7 - Driver door cancels accessory delay
// R8 - Switch positions signalled by grounding terminals
// R9 - Down plus auto grounded means auto
// R10 - Lock switch disables rear switches
// R11 - Parking lights light switch lamps
// R12 - Lock lamp lit while unlocked
// R13 - Master set and local switches both accepted
// R14 - Long down press latches express down
// R15 - Press stops express; release then repress
// R16 - Manual runs only while held
// R17 - Cranking pauses; express resumes afterwards
// R18 - Comparator inputs and counted cut-off delay
`timescale 1ns/1ps
`include "window_defines.svh"
module window_controller #(
	parameter int NUM_WIN     = `WIN_COUNT,
	parameter int EXPRESS_CYC = `WIN_EXPRESS_CYC,
	parameter int CUTOFF_CYC  = `WIN_CUTOFF_CYC,
	parameter int ACC_CYC     = `WIN_ACC_CYC
) (
	input  wire logic               clk_sys,
	input  wire logic               sys_rst,
	input  wire logic [NUM_WIN-1:0] master_raise_n,
	input  wire logic [NUM_WIN-1:0] master_lower_n,
	input  wire logic [NUM_WIN-1:0] master_auto_n,
	input  wire logic [NUM_WIN-1:0] local_raise_n,
	input  wire logic [NUM_WIN-1:0] local_lower_n,
	input  wire logic [NUM_WIN-1:0] local_auto_n,
	input  wire logic               ignition_on,
	input  wire logic               driver_door_open,
	input  wire logic               cranking,
	input  wire logic               window_lock,
	input  wire logic               parking_on,
	input  wire logic [NUM_WIN-1:0] current_over_run,
	input  wire logic [NUM_WIN-1:0] current_over_lock,
	output logic      [NUM_WIN-1:0] motor_raise,
	output logic      [NUM_WIN-1:0] motor_lower,
	output logic                    switch_lamp,
	output logic                    lock_lamp
);
	import window_pkg::*;
	localparam int W = 8 * NUM_WIN + 5;
	// Switches idle high, comparators and levels idle low
	localparam logic [W-1:0] SYNC_IDLE = {{6 * NUM_WIN{1'b1}},
		{2 * NUM_WIN{1'b0}}, 5'h00};
	logic [W-1:0] sync1_reg, sync2_reg;
	logic [31:0]  acc_reg;
	logic         ign_d_reg;
	wire [W-1:0] raw_in = {master_raise_n, master_lower_n, master_auto_n,
		local_raise_n, local_lower_n, local_auto_n, current_over_run,
		current_over_lock, ignition_on, driver_door_open, cranking,
		window_lock, parking_on};
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync1_reg <= SYNC_IDLE;
			sync2_reg <= SYNC_IDLE;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
		end
	end
	wire [NUM_WIN-1:0] m_up_n   = sync2_reg[W-1 -: NUM_WIN];
	wire [NUM_WIN-1:0] m_dn_n   = sync2_reg[W-1-NUM_WIN -: NUM_WIN];
	wire [NUM_WIN-1:0] m_au_n   = sync2_reg[W-1-2*NUM_WIN -: NUM_WIN];
	wire [NUM_WIN-1:0] l_up_n   = sync2_reg[W-1-3*NUM_WIN -: NUM_WIN];
	wire [NUM_WIN-1:0] l_dn_n   = sync2_reg[W-1-4*NUM_WIN -: NUM_WIN];
	wire [NUM_WIN-1:0] l_au_n   = sync2_reg[W-1-5*NUM_WIN -: NUM_WIN];
	wire [NUM_WIN-1:0] ov_run   = sync2_reg[W-1-6*NUM_WIN -: NUM_WIN];
	wire [NUM_WIN-1:0] ov_lock  = sync2_reg[W-1-7*NUM_WIN -: NUM_WIN];
	wire               ign_s    = sync2_reg[4];
	wire               door_s   = sync2_reg[3];
	wire               crank_s  = sync2_reg[2];
	wire               lock_s   = sync2_reg[1];
	wire               park_s   = sync2_reg[0];
	// Accessory delay keeps windows live after ignition off
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			acc_reg   <= '0;
			ign_d_reg <= 1'b0;
		end else begin
			ign_d_reg <= ign_s;
			if (ign_s || door_s)
				acc_reg <= '0; // R7
			else if (ign_d_reg)
				acc_reg <= 32'(ACC_CYC);
			else if (acc_reg != '0)
				acc_reg <= acc_reg - 1'b1;
		end
	end
	// No gap at ignition off; door drops the delay at once
	wire win_enable = ign_s ||
		(!door_s && (ign_d_reg || acc_reg != '0)); // R6 R7
	wire [NUM_WIN-1:0] rear_mask = {NUM_WIN{1'b1}} >> 2;
	wire [NUM_WIN-1:0] local_ok  = lock_s ? rear_mask : '1; // R10
	// Ground level means request; master and local merged
	wire [NUM_WIN-1:0] rq_up = ~m_up_n | (~l_up_n & local_ok); // R8 R13
	wire [NUM_WIN-1:0] rq_dn = ~m_dn_n | (~l_dn_n & local_ok); // R8 R13
	wire [NUM_WIN-1:0] rq_au = (~m_au_n & ~m_dn_n) |
		(~l_au_n & ~l_dn_n & local_ok); // R9
	genvar i;
	generate
		for (i = 0; i < NUM_WIN; i++) begin : g_win // R5
			window_channel #(
				.EXPRESS_CYC(EXPRESS_CYC),
				.CUTOFF_CYC (CUTOFF_CYC)
			) u_chan (
				.clk_sys   (clk_sys),
				.sys_rst   (sys_rst),
				.req_up    (rq_up[i]),
				.req_down  (rq_dn[i]),
				.req_auto  (rq_au[i]),
				.enable    (win_enable),
				.crank     (crank_s),
				.over_run  (ov_run[i]), // R3
				.over_lock (ov_lock[i] | (ov_run[i] & ov_lock[i])), // R3
				.motor_up  (motor_raise[i]),
				.motor_down(motor_lower[i])
			);
		end
	endgenerate
	logic sw_lamp_reg, lk_lamp_reg;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sw_lamp_reg <= 1'b0;
			lk_lamp_reg <= 1'b0;
		end else begin
			sw_lamp_reg <= park_s; // R11
			lk_lamp_reg <= park_s || !lock_s; // R12
		end
	end
	assign switch_lamp = sw_lamp_reg;
	assign lock_lamp   = lk_lamp_reg;
	chk_rear_lock : assert property (@(posedge clk_sys) disable iff (sys_rst)
		lock_s |-> (rq_up & ~rear_mask) == (~m_up_n & ~rear_mask))
		else $error("rear local request passed lock"); // R10
	chk_door_cancel : assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		door_s |=> acc_reg == '0) else $error("door kept delay"); // R7
	chk_lamp_park : assert property (@(posedge clk_sys) disable iff (sys_rst)
		park_s |=> switch_lamp && lock_lamp) else $error("lamp not lit"); // R11
endmodule : window_controller

// ### test/window_plant.sv
// Window glass travel and motor-current comparators for the bench
`timescale 1ns/1ps
module window_plant #(
	parameter int NUM_WIN = 4
) (
	input  wire logic               clk_sys,
	input  wire logic [NUM_WIN-1:0] motor_raise,
	input  wire logic [NUM_WIN-1:0] motor_lower,
	output logic      [NUM_WIN-1:0] current_over_run,
	output logic      [NUM_WIN-1:0] current_over_lock
);
	logic [8:0] pos_reg [NUM_WIN];
	initial foreach (pos_reg[i]) pos_reg[i] = 9'h080;
	always @(posedge clk_sys) begin
		foreach (pos_reg[i]) begin
			if (motor_raise[i] && pos_reg[i] != 9'h100)
				pos_reg[i] <= pos_reg[i] + 9'h001;
			else if (motor_lower[i] && pos_reg[i] != 9'h000)
				pos_reg[i] <= pos_reg[i] - 9'h001;
		end
	end
	// Stalled at an end draws locking current, above the running limit
	always_comb foreach (pos_reg[i]) begin
		current_over_lock[i] = (motor_raise[i] && pos_reg[i] == 9'h100)
			|| (motor_lower[i] && pos_reg[i] == 9'h000);
		current_over_run[i] = current_over_lock[i];
	end
endmodule : window_plant

// ### test/test_power_window_controller.sv
// Self-checking bench of the four-window controller
`timescale 1ns/1ps
module test_power_window_controller;
	localparam int EXP = 20;
	localparam int CUT = 5;
	localparam int ACC = 30;
	logic       clk_sys = 1'b0;
	logic       sys_rst = 1'b1;
	logic [3:0] m_up_n = 4'hF, m_dn_n = 4'hF, m_au_n = 4'hF;
	logic [3:0] l_up_n = 4'hF, l_dn_n = 4'hF, l_au_n = 4'hF;
	logic       ignition_on = 1'b1, driver_door_open = 1'b0;
	logic       cranking = 1'b0, window_lock = 1'b0, parking_on = 1'b0;
	logic       chk = 1'b0;
	wire  [3:0] cur_run, cur_lock, motor_raise, motor_lower;
	wire        switch_lamp, lock_lamp;
	logic [9:0] exp_q[$];
	int         fail_count = 0, n_compared = 0, cyc = 0;
	always #2.5 clk_sys = ~clk_sys;
	window_controller #(.EXPRESS_CYC(EXP), .CUTOFF_CYC(CUT),
		.ACC_CYC(ACC)) i_window_controller (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .master_raise_n(m_up_n),
		.master_lower_n(m_dn_n), .master_auto_n(m_au_n),
		.local_raise_n(l_up_n), .local_lower_n(l_dn_n),
		.local_auto_n(l_au_n), .ignition_on(ignition_on),
		.driver_door_open(driver_door_open), .cranking(cranking),
		.window_lock(window_lock), .parking_on(parking_on),
		.current_over_run(cur_run), .current_over_lock(cur_lock),
		.motor_raise(motor_raise), .motor_lower(motor_lower),
		.switch_lamp(switch_lamp), .lock_lamp(lock_lamp));
	window_plant #(.NUM_WIN(4)) i_window_plant (.clk_sys(clk_sys),
		.motor_raise(motor_raise), .motor_lower(motor_lower),
		.current_over_run(cur_run), .current_over_lock(cur_lock));
	task automatic close_out;
		$display("compared=%0d errors=%0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task automatic tick(int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	// Switch positions, active high here, grounded at the pins
	task automatic sw(logic [3:0] mu, md, ma, lu, ld, la);
		m_up_n <= ~mu;
		m_dn_n <= ~md;
		m_au_n <= ~ma;
		l_up_n <= ~lu;
		l_dn_n <= ~ld;
		l_au_n <= ~la;
	endtask : sw
	// Note the expected outputs, then let the watcher compare them
	task automatic expect_out(logic [3:0] r, logic [3:0] l);
		exp_q.push_back({r, l, parking_on, ~window_lock | parking_on});
		chk <= 1'b1;
		tick(1);
		chk <= 1'b0;
	endtask : expect_out
	task automatic compare_out(logic [9:0] e);
		logic [9:0] got;
		got = {motor_raise, motor_lower, switch_lamp, lock_lamp};
		n_compared++;
		if (got !== e) begin
			fail_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, got);
		end
	endtask : compare_out
	always @(negedge clk_sys) if (chk) compare_out(exp_q.pop_front());
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			close_out();
		end
	end
	initial begin
		logic [3:0] r, l;
		void'($urandom(32'hF36F5FC5));
		tick(5);
		sys_rst <= 1'b0;
		tick(5);
		expect_out(4'h0, 4'h0);
		for (int i = 0; i < 4; i++) begin
			sw(4'h1 << i, 0, 0, 0, 0, 0);
			tick(5);
			expect_out(4'h1 << i, 4'h0);
			sw(0, 0, 0, 0, 0, 0);
			tick(5);
			sw(0, 0, 0, 0, 4'h1 << i, 0);
			tick(5);
			expect_out(4'h0, 4'h1 << i);
			sw(0, 0, 0, 0, 0, 0);
			tick(5);
			expect_out(4'h0, 4'h0);
		end
		sw(0, 0, 0, 0, 4'h2, 4'h2);
		tick(EXP + 6);
		sw(0, 0, 0, 0, 0, 0);
		tick(5);
		expect_out(4'h0, 4'h2);
		for (int k = 0; k < 400 && !cur_lock[1]; k++) tick(1);
		tick(CUT + 5);
		expect_out(4'h0, 4'h0);
		sw(0, 4'h1, 0, 0, 0, 0);
		tick(EXP + 6);
		sw(0, 0, 0, 0, 0, 0);
		tick(5);
		expect_out(4'h0, 4'h1);
		sw(4'h1, 0, 0, 0, 0, 0);
		tick(5);
		expect_out(4'h0, 4'h0);
		sw(0, 0, 0, 0, 0, 0);
		tick(5);
		sw(4'h1, 0, 0, 0, 0, 0);
		tick(5);
		expect_out(4'h1, 4'h0);
		sw(0, 0, 0, 0, 4'h4, 0);
		tick(EXP + 6);
		sw(0, 0, 0, 0, 0, 0);
		tick(5);
		cranking <= 1'b1;
		tick(5);
		expect_out(4'h0, 4'h0);
		cranking <= 1'b0;
		tick(5);
		expect_out(4'h0, 4'h4);
		sw(4'h8, 0, 0, 0, 4'h4, 0);
		tick(5);
		cranking <= 1'b1;
		tick(5);
		expect_out(4'h0, 4'h0);
		cranking <= 1'b0;
		tick(5);
		expect_out(4'h8, 4'h0);
		sw(0, 0, 0, 0, 0, 0);
		window_lock <= 1'b1;
		parking_on <= 1'b1;
		tick(5);
		sw(0, 0, 0, 4'hF, 0, 0);
		tick(5);
		expect_out(4'h3, 4'h0);
		sw(0, 0, 0, 0, 0, 0);
		window_lock <= 1'b0;
		parking_on <= 1'b0;
		tick(5);
		expect_out(4'h0, 4'h0);
		for (int n = 0; n < 3; n++) begin
			r = 4'($urandom_range(1, 15));
			l = ~r & 4'($urandom);
			sw(r, 0, 0, 0, l, 0);
			tick(5);
			expect_out(r, l);
			sw(0, 0, 0, 0, 0, 0);
			tick(5);
		end
		ignition_on <= 1'b0;
		tick(2);
		sw(4'hF, 0, 0, 0, 0, 0);
		tick(5);
		expect_out(4'hF, 4'h0);
		driver_door_open <= 1'b1;
		tick(5);
		expect_out(4'h0, 4'h0);
		sw(0, 0, 0, 0, 0, 0);
		driver_door_open <= 1'b0;
		tick(ACC + 10);
		sw(0, 0, 0, 0, 4'hF, 0);
		tick(5);
		expect_out(4'h0, 4'h0);
		sw(0, 0, 0, 0, 0, 0);
		tick(3);
		close_out();
	end
endmodule : test_power_window_controller
